// file: rtl/sar_adc_sequencer.v
// converter sequencer top: apb register file, conversion state machine, sleep handling
//
// The register addresses and the APB slave port are this design's own decisions.
module sar_adc_sequencer (
  input wire pclk, // system clock, 40 MHz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire comp_in, // analog comparator result pin
  input wire frc_osc, // internal oscillator pin
  input wire event_trigger, // capture_compare_unit special event
  input wire sleep, // cpu in sleep
  output reg [3:0] chan_sel, // analog mux channel
  output reg pos_ref_ext, // positive reference: 1 external pin
  output reg neg_ref_gnd, // negative reference tied to ground
  output reg sample_hold, // 1 acquire, 0 hold
  output reg converter_powered, // analog block power
  output wire [9:0] dac_code, // trial code to the dac
  output reg timer_clear, // clears the 16-bit timer, pulse
  output reg irq, // completion interrupt request
  output reg wake // wake request from sleep
);
`include "sar_adc_defines.vh"

  localparam [7:0] CTRL0_INIT = `CTRL0_RST;
  localparam [7:0] CTRL1_INIT = `CTRL1_RST;
  localparam ST_IDLE = 3'h0;
  localparam ST_DELAY = 3'h1;
  localparam ST_FIRST = 3'h2;
  localparam ST_BITS = 3'h3;
  localparam ST_ABORT = 3'h4;

  localparam IX_CTRL0 = 3'h0;
  localparam IX_CTRL1 = 3'h1;
  localparam IX_RES_HIGH = 3'h2;
  localparam IX_RES_LOW = 3'h3;
  localparam IX_FLAG = 3'h4;
  localparam IX_IRQ_EN = 3'h5;
  localparam IX_NONE = 3'h7;

  function [2:0] reg_index;
    input [7:0] a;
    begin
      case (a)
        `OFS_CTRL0: reg_index = IX_CTRL0;
        `OFS_CTRL1: reg_index = IX_CTRL1;
        `OFS_RES_HIGH: reg_index = IX_RES_HIGH;
        `OFS_RES_LOW: reg_index = IX_RES_LOW;
        `OFS_FLAG: reg_index = IX_FLAG;
        `OFS_IRQ_EN: reg_index = IX_IRQ_EN;
        default: reg_index = IX_NONE;
      endcase
    end
  endfunction

  // control and status
  reg justify;
  reg go;
  reg power_en;
  reg [2:0] clk_sel;
  reg [7:0] res_high;
  reg [7:0] res_low;
  reg done_flag;
  reg irq_en;
  reg [2:0] st;
  reg [1:0] abort_cnt;
  reg [2:0] dly_cnt;
  reg sleep_off;

  // pin synchronisers: comp, trigger, oscillator
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3;
  reg [2:0] filt;
  reg [2:0] filt_d;

  wire [2:0] pins;
  wire comp_f;
  wire trig_rise;
  wire frc_rise;
  wire setup;
  wire wr_take;
  wire [2:0] idx;
  wire wr_ctrl0;
  wire busy;
  wire frc_mode;
  wire tick;
  wire last;
  wire run;
  wire sar_start;
  wire sar_step;
  wire done;
  wire start_req;
  wire abort_sw;
  wire off_sw;
  wire sleep_abort;
  wire flag_clr;
  wire [9:0] final_code;
  wire [7:0] next_res_high;
  wire [7:0] next_res_low;
  reg [31:0] rd_mux;

  assign pins = {frc_osc, event_trigger, comp_in};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      filt <= 3'h0;
      filt_d <= 3'h0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      // a change counts only once stages two and three agree
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
      filt_d <= filt;
    end
  end

  assign comp_f = filt[0];
  assign trig_rise = filt[1] & ~filt_d[1];
  assign frc_rise = filt[2] & ~filt_d[2];

  // apb: setup cycle captures data, one-cycle access phase
  assign setup = psel & ~penable;
  assign wr_take = psel & penable & pready & pwrite;
  assign idx = reg_index(paddr);
  assign wr_ctrl0 = wr_take & (idx == IX_CTRL0);
  assign flag_clr = wr_take & (idx == IX_FLAG) & pwdata[`FLAG_DONE];

  always @* begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IX_CTRL0: begin
        rd_mux[`CTRL0_JUST] = justify;
        rd_mux[`CTRL0_CHS_HI:`CTRL0_CHS_LO] = chan_sel;
        rd_mux[`CTRL0_GO] = go;
        rd_mux[`CTRL0_ON] = power_en;
      end
      IX_CTRL1: begin
        rd_mux[`CTRL1_CS_HI:`CTRL1_CS_LO] = clk_sel;
        rd_mux[`CTRL1_PREF] = pos_ref_ext;
      end
      IX_RES_HIGH: rd_mux[7:0] = res_high;
      IX_RES_LOW: rd_mux[7:0] = res_low;
      IX_FLAG: rd_mux[`FLAG_DONE] = done_flag;
      IX_IRQ_EN: rd_mux[`IRQ_EN_DONE] = irq_en;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & (idx == IX_NONE);
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // sequencing
  assign busy = (st == ST_DELAY) | (st == ST_FIRST) | (st == ST_BITS);
  assign frc_mode = (clk_sel[1:0] == `CS_FRC);
  assign run = (st == ST_FIRST) | (st == ST_BITS) | (st == ST_ABORT);
  assign sar_start = (st == ST_FIRST) & tick;
  assign sar_step = (st == ST_BITS) & tick;
  assign done = sar_step & last;
  // go in the same write that powers on is ignored; power must already be on
  assign start_req = (st == ST_IDLE) & power_en & ~sleep_off
    & ((wr_ctrl0 & pwdata[`CTRL0_GO]) | trig_rise);
  assign abort_sw = wr_ctrl0 & ~pwdata[`CTRL0_GO] & busy;
  assign off_sw = wr_ctrl0 & ~pwdata[`CTRL0_ON];
  assign sleep_abort = sleep & ~frc_mode & busy;
  assign final_code = {dac_code[9:1], comp_f};
  assign next_res_high = justify ? {6'h00, final_code[9:8]} : final_code[9:2];
  assign next_res_low = justify ? final_code[7:0] : {final_code[1:0], 6'h00};

  conv_clock_gen u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .run(run & ~(abort_sw | sleep_abort)),
    .sel(clk_sel),
    .frc_rise(frc_rise),
    .tick(tick)
  );

  sar_register #(
    .WIDTH(`RES_BITS)
  ) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(sar_start),
    .step(sar_step),
    .comp(comp_f),
    .code(dac_code),
    .last(last)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      justify <= CTRL0_INIT[`CTRL0_JUST];
      chan_sel <= CTRL0_INIT[`CTRL0_CHS_HI:`CTRL0_CHS_LO];
      go <= CTRL0_INIT[`CTRL0_GO];
      power_en <= CTRL0_INIT[`CTRL0_ON];
      clk_sel <= CTRL1_INIT[`CTRL1_CS_HI:`CTRL1_CS_LO];
      pos_ref_ext <= CTRL1_INIT[`CTRL1_PREF];
      irq_en <= 1'b0;
    end else begin
      if (wr_take & (idx == IX_CTRL0)) begin
        justify <= pwdata[`CTRL0_JUST];
        chan_sel <= pwdata[`CTRL0_CHS_HI:`CTRL0_CHS_LO];
        power_en <= pwdata[`CTRL0_ON];
      end
      if (wr_take & (idx == IX_CTRL1)) begin
        clk_sel <= pwdata[`CTRL1_CS_HI:`CTRL1_CS_LO];
        pos_ref_ext <= pwdata[`CTRL1_PREF];
      end
      if (wr_take & (idx == IX_IRQ_EN)) begin
        irq_en <= pwdata[`IRQ_EN_DONE];
      end
      // busy bit: the plain write never loads it; only the hardware set and clear conditions move it
      if (start_req) begin
        go <= 1'b1;
      end else if (done | off_sw | sleep_abort | abort_sw) begin
        go <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_IDLE;
      abort_cnt <= 2'h0;
      dly_cnt <= 3'h0;
    end else if (off_sw | sleep_abort) begin
      st <= ST_IDLE;
      abort_cnt <= 2'h0;
      dly_cnt <= 3'h0;
    end else if (abort_sw) begin
      st <= ST_ABORT;
      abort_cnt <= 2'h0;
      dly_cnt <= 3'h0;
    end else begin
      case (st)
        ST_IDLE: begin
          dly_cnt <= 3'h0;
          if (start_req) begin
            st <= frc_mode ? ST_DELAY : ST_FIRST;
          end
        end
        ST_DELAY: begin
          // one instruction lets the cpu enter sleep before the noisy part
          if (dly_cnt == `INSTR_CLKS - 3'h1) begin
            st <= ST_FIRST;
          end else begin
            dly_cnt <= dly_cnt + 3'h1;
          end
        end
        ST_FIRST: begin
          if (tick) begin
            st <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (done) begin
            st <= ST_IDLE;
          end
        end
        ST_ABORT: begin
          if (tick) begin
            if (abort_cnt == `ABORT_TADS - 2'h1) begin
              st <= ST_IDLE;
              abort_cnt <= 2'h0;
            end else begin
              abort_cnt <= abort_cnt + 2'h1;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // result pair loads only on completion, never on abort or software write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_high <= `RES_RST;
      res_low <= `RES_RST;
    end else if (done) begin
      res_high <= next_res_high;
      res_low <= next_res_low;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
    end else begin
      // a completion in the clearing cycle is kept
      done_flag <= done | (done_flag & ~flag_clr);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_off <= 1'b0;
    end else if (!sleep) begin
      sleep_off <= 1'b0;
    end else if (sleep_abort | (done & ~irq_en)) begin
      sleep_off <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      wake <= 1'b0;
      timer_clear <= 1'b0;
      sample_hold <= 1'b0;
      converter_powered <= 1'b0;
      neg_ref_gnd <= 1'b1;
    end else begin
      irq <= done_flag & irq_en;
      wake <= sleep & done_flag & irq_en;
      timer_clear <= trig_rise & start_req;
      converter_powered <= power_en & ~sleep_off;
      sample_hold <= power_en & ~sleep_off & (st == ST_IDLE);
      neg_ref_gnd <= 1'b1;
    end
  end

endmodule // sar_adc_sequencer

// file: rtl/sar_adc_defines.vh
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_RES_HIGH 8'h08
`define OFS_RES_LOW 8'h0C
`define OFS_FLAG 8'h10
`define OFS_IRQ_EN 8'h14

`define CTRL0_ON 0
`define CTRL0_GO 1
`define CTRL0_CHS_LO 2
`define CTRL0_CHS_HI 5
`define CTRL0_JUST 7
`define CTRL1_PREF 0
`define CTRL1_CS_LO 4
`define CTRL1_CS_HI 6
`define FLAG_DONE 0
`define IRQ_EN_DONE 0

`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h00
`define RES_RST 8'h00

`define RES_BITS 10
`define TAD_TOTAL 4'hB
`define ABORT_TADS 2'h2
`define FRC_DIV 5'h10
`define INSTR_CLKS 3'h4
`define CS_FRC 2'h3

`endif

// file: rtl/conv_clock_gen.v
// bit-conversion period tick generator: divided system clock or divided internal oscillator
module conv_clock_gen (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire run, // count while high, restart when low
  input wire [2:0] sel, // conversion clock select
  input wire frc_rise, // filtered rising edge of the internal oscillator
  output reg tick // one-cycle pulse per bit-conversion period
);
`include "sar_adc_defines.vh"

  wire frc_mode;
  wire [2:0] shift;
  wire [6:0] div_last;
  reg [6:0] cnt;
  reg [4:0] fcnt;

  assign frc_mode = (sel[1:0] == `CS_FRC);
  // reordered select gives a monotonic shift: 000->/2 ... 110->/64
  assign shift = {sel[1:0], sel[2]};
  assign div_last = (7'h02 << shift) - 7'h01;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 7'h00;
      fcnt <= 5'h00;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= 7'h00;
      fcnt <= 5'h00;
      tick <= 1'b0;
    end else if (frc_mode) begin
      tick <= 1'b0;
      if (frc_rise) begin
        if (fcnt == `FRC_DIV - 5'h01) begin
          fcnt <= 5'h00;
          tick <= 1'b1;
        end else begin
          fcnt <= fcnt + 5'h01;
        end
      end
    end else if (cnt == div_last) begin
      cnt <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      tick <= 1'b0;
    end
  end
endmodule // conv_clock_gen

// file: rtl/sar_register.v
// successive-approximation register: trial code and bit pointer
module sar_register #(
  parameter WIDTH = 10 // result width
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire start, // load the first trial code
  input wire step, // decide the current bit from comp
  input wire comp, // comparator: input above trial code
  output reg [WIDTH-1:0] code, // trial code to the converter's dac
  output wire last // current bit is the lsb
);
  reg [3:0] idx;

  assign last = (idx == 4'h0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code <= {WIDTH{1'b0}};
      idx <= 4'h0;
    end else if (start) begin
      code <= {1'b1, {(WIDTH-1){1'b0}}};
      idx <= WIDTH[3:0] - 4'h1;
    end else if (step) begin
      code[idx] <= comp;
      if (idx != 4'h0) begin
        code[idx-4'h1] <= 1'b1;
        idx <= idx - 4'h1;
      end
    end
  end
endmodule // sar_register

// file: bench/adc_front_model.sv
// analog mux and sample-and-hold model driving the comparator pin
module adc_front_model (
  input logic pclk, // system clock
  input logic [3:0] chan_sel, // selected channel
  input logic sample_hold, // 1 acquire, 0 hold
  input logic [9:0] dac_code, // trial code
  output logic comp_in // input above trial code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  // tracks the channel while acquiring, frozen while holding
  always @(posedge pclk)
    if (sample_hold)
      held <= 10'h3FF - 10'(chan_sel) * 10'h093;
  // half-lsb offset so the code settles on the held value exactly
  assign comp_in = {held, 1'b1} > {dac_code, 1'b0};
endmodule // adc_front_model

// file: bench/sar_adc_sequencer_chk.sv
// port assertions for the converter sequencer
module sar_adc_sequencer_chk (
  input logic pclk, // clock
  input logic presetn, // reset, active low
  input logic psel, // apb select
  input logic penable, // apb enable
  input logic pwrite, // apb direction
  input logic pready, // apb ready
  input logic pslverr, // apb error
  input logic sleep, // cpu sleep
  input logic [3:0] chan_sel, // mux channel
  input logic pos_ref_ext, // reference select
  input logic neg_ref_gnd, // negative reference
  input logic sample_hold, // acquire
  input logic converter_powered, // analog power
  input logic timer_clear, // timer clear pulse
  input logic irq, // interrupt
  input logic wake // wake request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable & pwrite;
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_neg_ground: assert property (neg_ref_gnd)
    else $error("negative reference off ground");
  chk_ref_by_write: assert property ($changed(pos_ref_ext) |-> $past(acc))
    else $error("reference moved without write");
  chk_chan_by_write: assert property ($changed(chan_sel) |-> $past(acc))
    else $error("channel moved without write");
  chk_hold_powered: assert property (sample_hold |-> converter_powered)
    else $error("acquiring while unpowered");
  chk_wake_sleep: assert property (wake |-> $past(sleep))
    else $error("wake outside sleep");
  chk_irq_kept: assert property ($fell(irq) |-> $past(acc) || $past(acc, 2))
    else $error("interrupt dropped without write");
  chk_clear_pulse: assert property (timer_clear |=> !timer_clear)
    else $error("timer clear too long");
endmodule // sar_adc_sequencer_chk
bind sar_adc_sequencer sar_adc_sequencer_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .sleep(sleep), .chan_sel(chan_sel),
  .pos_ref_ext(pos_ref_ext), .neg_ref_gnd(neg_ref_gnd), .sample_hold(sample_hold),
  .converter_powered(converter_powered), .timer_clear(timer_clear), .irq(irq), .wake(wake));

// file: bench/sar_adc_sequencer_tb.sv
// self-checking bench for the converter sequencer
module sar_adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic frc_osc = 0, event_trigger = 0, sleep = 0, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, comp_in, neg_ref_gnd, sample_hold, converter_powered;
  logic pos_ref_ext, timer_clear, irq, wake;
  logic [3:0] chan_sel;
  logic [9:0] dac_code;
  int err_count = 0, compares = 0;
  always #12.5 pclk = ~pclk;
  // free-running oscillator; each level spans two pclk samples so the filter sees every rise
  always #50 frc_osc = ~frc_osc;
  sar_adc_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .frc_osc(frc_osc), .event_trigger(event_trigger),
    .sleep(sleep), .chan_sel(chan_sel), .pos_ref_ext(pos_ref_ext), .neg_ref_gnd(neg_ref_gnd),
    .sample_hold(sample_hold), .converter_powered(converter_powered), .dac_code(dac_code),
    .timer_clear(timer_clear), .irq(irq), .wake(wake));
  adc_front_model i_front (.pclk(pclk), .chan_sel(chan_sel), .sample_hold(sample_hold),
    .dac_code(dac_code), .comp_in(comp_in));
  task automatic finish_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hang;
    err_count++;
    $display("BAD %0t wait ran out", $time);
    finish_test;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // entered just after an edge; returns one edge after the release
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang;
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, r);
    ck(r, e);
  endtask
  task automatic wait_idle(output int n);
    n = 2;
    repeat (2) @(posedge pclk);
    while (sample_hold !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 3000) hang;
    end
  endtask
  task automatic conv(input logic [7:0] c0, output int n);
    repeat (8) @(posedge pclk);
    wr(8'h00, {24'h0, c0 | 8'h02});
    wait_idle(n);
  endtask
  task automatic res(input logic [9:0] v, input logic rj);
    rd(8'h08, rj ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
    rd(8'h0C, rj ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
  endtask
  task automatic t_reset;
    for (int a = 0; a < 6; a++)
      rd(8'(a * 4), 32'h0);
    ck(neg_ref_gnd, 1'b1);
    rd(8'h18, 32'h0);
    ck(last_err, 1'b1);
    wr(8'h00, 32'h03);
    rd(8'h00, 32'h01);
    ck(sample_hold, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_conv;
    logic [2:0] cs [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int dv [7] = '{2, 4, 8, 16, 32, 64, 0};
    logic [7:0] c0;
    int n;
    for (int i = 0; i < 7; i++) begin
      c0 = {i[0], 1'b0, 4'(i), 2'b01};
      wr(8'h04, {25'h0, cs[i], 4'h1});
      wr(8'h00, {24'h0, c0});
      ck(chan_sel, 4'(i));
      conv(c0, n);
      if (dv[i] == 0)
        ck(n >= 706 && n <= 714, 1'b1);
      else
        ck(n >= 11 * dv[i] && n <= 11 * dv[i] + 8, 1'b1);
      rd(8'h00, {24'h0, c0});
      rd(8'h10, 32'h1);
      wr(8'h08, 32'hFF);
      wr(8'h0C, 32'hFF);
      // fast clocks outrun the comparator path, so only timing is judged there
      if (dv[i] == 0 || dv[i] >= 8)
        res(10'h3FF - 10'(i) * 10'h093, i[0]);
      wr(8'h10, 32'h1);
      rd(8'h10, 32'h0);
    end
    ck(pos_ref_ext, 1'b1);
    $display("test conversion done");
  endtask
  task automatic t_irq;
    int n;
    wr(8'h04, 32'h50);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h89);
    conv(8'h89, n);
    @(posedge pclk);
    ck(irq, 1'b1);
    wr(8'h10, 32'h1);
    @(posedge pclk);
    ck(irq, 1'b0);
    wr(8'h14, 32'h0);
    conv(8'h89, n);
    repeat (20) @(posedge pclk);
    ck(irq, 1'b0);
    rd(8'h10, 32'h1);
    wr(8'h10, 32'h1);
    res(10'h2D9, 1'b1);
    $display("test irq done");
  endtask
  task automatic t_abort;
    int n;
    wr(8'h04, 32'h60);
    wr(8'h00, 32'h95);
    repeat (8) @(posedge pclk);
    wr(8'h00, 32'h97);
    repeat (200) @(posedge pclk);
    wr(8'h00, 32'h95);
    wait_idle(n);
    ck(n >= 124 && n <= 140, 1'b1);
    res(10'h2D9, 1'b1);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h97);
    repeat (100) @(posedge pclk);
    sleep <= 1'b1;
    repeat (6) @(posedge pclk);
    ck(converter_powered, 1'b0);
    rd(8'h00, 32'h95);
    sleep <= 1'b0;
    repeat (4) @(posedge pclk);
    ck(converter_powered, 1'b1);
    res(10'h2D9, 1'b1);
    $display("test abort done");
  endtask
  task automatic t_frc(input logic en);
    int n;
    wr(8'h04, 32'h30);
    wr(8'h14, {31'h0, en});
    wr(8'h00, 32'h8D);
    repeat (8) @(posedge pclk);
    wr(8'h00, 32'h8F);
    sleep <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    ck(n < 1000, en);
    ck(converter_powered, en);
    sleep <= 1'b0;
    @(posedge pclk);
    rd(8'h00, 32'h8D);
    rd(8'h10, 32'h1);
    res(10'h246, 1'b1);
    wr(8'h10, 32'h1);
    $display("test sleep done");
  endtask
  task automatic t_trig;
    int n;
    wr(8'h04, 32'h50);
    wr(8'h00, 32'h99);
    repeat (8) @(posedge pclk);
    event_trigger <= 1'b1;
    n = 0;
    while (timer_clear !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    ck(n < 20, 1'b1);
    event_trigger <= 1'b0;
    wait_idle(n);
    rd(8'h10, 32'h1);
    res(10'h08D, 1'b1);
    wr(8'h00, 32'h9B);
    repeat (50) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    ck(converter_powered, 1'b0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h0);
    rd(8'h0C, 32'h0);
    $display("test trigger and reset done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_conv;
    t_irq;
    t_abort;
    t_frc(1'b0);
    t_frc(1'b1);
    t_trig;
    finish_test;
  end
endmodule // sar_adc_sequencer_tb
